/* File: hw/sbcu_pkg.sv */
// Shared constants and types of the system bus cycle unit.
// Assumes a reference clock at twice the bus clock: two ticks form one bus state.
package sbcu_pkg;

  // Ticks of the reference clock in one bus clock; tick 0 is the first half.
  localparam int TICKS_PER_BUS_CLK = 2;

  // Slave cycle timing, counted in ticks from the edge that took chip select.
  localparam logic [2:0] SLV_ACK_TICK = 3'h2;
  localparam logic [2:0] SLV_WLATCH_TICK = 3'h6;
  localparam logic [2:0] SLV_SZACK_TICK = 3'h6;
  localparam logic [2:0] SLV_CNT_MAX = 3'h7;

  // Reset and idle values.
  localparam logic [31:0] DATA_RST = 32'h0000_0000;
  localparam logic [30:0] ADDR_RST = 31'h0000_0000;
  localparam logic [2:0] STATUS_IDLE = 3'h7;
  localparam logic [1:0] WAIT_RST = 2'h0;

  // Bit positions in the synchroniser vector.
  localparam int SY_BUS_ENDIAN_SELECT = 0;
  localparam int SY_DSACK = 1;
  localparam int SY_SYNC_CYCLE_END = 3;
  localparam int SY_RDY = 4;
  localparam int SY_BRT = 5;
  localparam int SY_CS = 6;
  localparam int SY_SAS = 7;
  localparam int SY_SDIR = 8;
  localparam int SY_RIDX = 9;
  localparam int SY_DATA = 15;
  localparam int SY_W = 47;

  // Register file shape.
  localparam int REG_IDX_W = 6;
  localparam int REG_DATA_W = 16;
  localparam int REG_DEPTH = 64;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_T1 = 6'h02,
    ST_TW = 6'h04,
    ST_T2 = 6'h08,
    ST_TH = 6'h10,
    ST_SLV = 6'h20
  } bus_state_t;

endpackage

/* File: hw/sbcu_regfile.sv */
// Register storage behind the slave port, 64 words of 16 bits.
// Assumes writes and reads come from the bus cycle unit on the same clock.
`timescale 1ns/1ps
module sbcu_regfile import sbcu_pkg::*; (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Write port
  input wire logic i_wr_en,
  input wire logic [REG_IDX_W-1:0] i_wr_idx,
  input wire logic [REG_DATA_W-1:0] i_wr_data,
  // Read port
  input wire logic [REG_IDX_W-1:0] i_rd_idx,
  output logic [REG_DATA_W-1:0] o_rd_data
);

  logic [REG_DATA_W-1:0] mem_q [REG_DEPTH];

  // The array has no reset so that it maps onto plain memory.
  always_ff @(posedge i_ref_clk) begin
    if (i_wr_en) begin
      mem_q[i_wr_idx] <= i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rd_data <= '0;
    end else begin
      o_rd_data <= mem_q[i_rd_idx];
    end
  end

endmodule

/* File: hw/sbcu_core.sv */
// System bus cycle unit: master memory cycles and big-endian slave register access.
// Assumes i_ref_clk runs at twice the bus clock; pins pass two flip-flops first.
//
// Summary of operation
// [R1] Big-endian: early strobe T1, address strobe mid-T1.
// [R2] Async size-ack sampled mid-T1 and mid-T2.
// [R3] Sync termination sampled at start of T2.
// [R4] End 1.5 clocks after size-ack, 1 after sync.
// [R5] Repeat T2 until termination seen low.
// [R6] Big-endian async data strobe and data timing.
// [R7] No strobe for zero-wait writes; release mid-T2.
// [R8] Far side keeps termination inactive during T1.
// [R9] Little-endian: address strobe T1, early strobe half.
// [R10] Little-endian sync: ready sampled ending T2.
// [R11] Little-endian sync: data capture and write drive.
// [R12] Little-endian async: ready mid-T1/T2, end 1.5 clocks.
// [R13] Little-endian async data strobe timing.
// [R14] Retry ends cycle, then grant released.
// [R15] Retry repeats cycle, or waits in latched mode.
// [R16] Retry outranks every normal termination.
// [R17] Retry sampled synchronously or via synchroniser.
// [R18] Far side: async retry only with async cycles.
// [R19] Slave cycle starts only with chip select.
// [R20] Slave acknowledge one clock after chip select.
// [R21] Read data with acknowledge; write latched later.
// [R22] Release on strobe or select; 16 data bits.
// [R23] Programmed waits 0 to 3 before T2.
// [R24] Mode pin picks endian; bit picks sync.
// [R25] Far side spaces chip select and memory request.
// [R26] Retry sets a status bit software clears.
`timescale 1ns/1ps
module sbcu_core import sbcu_pkg::*; (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Configuration
  input wire logic i_bus_endian_select,
  input wire logic i_sync_master_select,
  input wire logic [1:0] i_wait_count_bits,
  input wire logic i_latched_retry_mode,
  input wire logic i_retry_sampling_select,
  input wire logic i_retry_status_clear,
  output logic o_retry_status_bit,
  // Transfer requests from the DMA
  input wire logic i_xfer_req,
  input wire logic i_xfer_write,
  input wire logic [31:1] i_xfer_addr,
  input wire logic [2:0] i_xfer_status,
  input wire logic [31:0] i_xfer_wdata,
  output logic o_xfer_done,
  output logic [31:0] o_xfer_rdata,
  // Master bus pins
  output logic [31:1] o_addr,
  output logic [2:0] o_bus_status_lines,
  output logic o_master_dir_be,
  output logic o_master_dir_le,
  output logic o_early_cycle_strobe_n,
  output logic o_addr_valid_strobe_be_n,
  output logic o_addr_valid_strobe_le_n,
  output logic o_data_valid_strobe_n,
  output logic o_grant_acknowledge_n,
  input wire logic [1:0] i_size_ack_pair_n,
  input wire logic i_sync_cycle_end_n,
  input wire logic i_ready_in_n,
  input wire logic i_retry_request_n,
  // Shared data pins
  input wire logic [31:0] i_data,
  output logic [31:0] o_data,
  output logic o_data_oe_n,
  // Slave pins
  input wire logic i_chip_select_n,
  input wire logic i_slave_addr_strobe_n,
  input wire logic i_slave_dir,
  input wire logic [5:0] i_register_index,
  output logic o_slave_mem_acknowledge_n,
  output logic [1:0] o_size_ack_out_n
);

  ////////////////////////////////////////////////////////////////////////////////
  logic [SY_W-1:0] sy_in;
  logic [SY_W-1:0] sy1_q;
  logic [SY_W-1:0] sy2_q;
  logic be, dsack_lo, sync_cycle_end_lo, rdy_lo, retry_request, cs, slave_addr_strobe, sdir;
  logic [5:0] ridx;
  logic [31:0] din;
  bus_state_t state_q;
  logic ph_q, wr_q, nw_nz_q, wfirst_q, term_q, end_q, retry_q, armed_q, done_q;
  logic [1:0] wcnt_q;
  logic [2:0] scnt_q;
  logic [2:0] stat_q;
  logic [31:1] addr_q;
  logic [31:0] dout_q, rdata_q;
  logic [15:0] rf_rdata;
  logic in_idle, in_t1, in_tw, in_t2, in_th, in_slv, async_m;
  logic into_t2, mid_win, fin, retry_hit, start_ok, slave_go, t2_live;
  logic as_be, ds_rd, ds_wr, ack, szack, rf_we;

  // Pins come from outside the clock domain, so all of them are synchronised.
  assign sy_in = {i_data, i_register_index, i_slave_dir, i_slave_addr_strobe_n,
                  i_chip_select_n, i_retry_request_n, i_ready_in_n,
                  i_sync_cycle_end_n, i_size_ack_pair_n, i_bus_endian_select};

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      sy1_q <= '1;
      sy2_q <= '1;
    end else begin
      sy1_q <= sy_in;
      sy2_q <= sy1_q;
    end
  end

  // The mode pin is static; it is read through the synchroniser. [R24]
  assign be = sy2_q[SY_BUS_ENDIAN_SELECT];
  assign dsack_lo = (sy2_q[SY_DSACK +: 2] == 2'h0);
  assign sync_cycle_end_lo = ~sy2_q[SY_SYNC_CYCLE_END];
  assign rdy_lo = ~sy2_q[SY_RDY];
  assign retry_request = ~sy2_q[SY_BRT];
  assign cs = ~sy2_q[SY_CS];
  assign slave_addr_strobe = ~sy2_q[SY_SAS];
  assign sdir = sy2_q[SY_SDIR];
  assign ridx = sy2_q[SY_RIDX +: 6];
  assign din = sy2_q[SY_DATA +: 32];

  ////////////////////////////////////////////////////////////////////////////////
  assign in_idle = (state_q == ST_IDLE);
  assign in_t1 = (state_q == ST_T1);
  assign in_tw = (state_q == ST_TW);
  assign in_t2 = (state_q == ST_T2);
  assign in_th = (state_q == ST_TH);
  assign in_slv = (state_q == ST_SLV);
  assign async_m = ~i_sync_master_select; // [R24]

  // Edge that opens a T2; termination is ignored before the middle of the last programmed wait. [R23]
  assign into_t2 = ph_q & ((in_t1 & (wcnt_q == 2'h0)) | (in_tw & (wcnt_q == 2'h1))
                           | (in_t2 & ~fin));
  // Mid-state edges where async termination is looked at. [R2] [R12]
  assign mid_win = ~ph_q & ((in_t1 & (wcnt_q == 2'h0)) | (in_tw & (wcnt_q == 2'h1))
                            | (in_t2 & ~end_q));
  // Little-endian sync ready is taken on the edge that ends T2. [R10]
  assign fin = in_t2 & ph_q & (end_q | retry_q | (~be & ~async_m & rdy_lo)); // [R5]
  // Async retry is seen from mid-T1 on; sync retry only at the start of T2. [R17]
  assign retry_hit = retry_request & (i_retry_sampling_select ?
                     ((in_t1 & ~ph_q) | in_tw | (in_t2 & ~ph_q)) : into_t2);
  // The done tick is skipped so a request dropped on done is not taken twice. [R15]
  assign start_ok = i_xfer_req & ~done_q & ~(i_latched_retry_mode & (o_retry_status_bit | retry_request));
  // Slave cycles exist in big-endian mode only and need a fresh strobe. [R19]
  assign slave_go = be & cs & slave_addr_strobe & armed_q;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (slave_go) begin
            state_q <= ST_SLV;
          end else if (start_ok) begin
            state_q <= ST_T1;
          end
        end
        ST_T1: begin
          if (ph_q) begin
            state_q <= (wcnt_q != 2'h0) ? ST_TW : ST_T2; // [R23]
          end
        end
        ST_TW: begin
          if (ph_q && wcnt_q == 2'h1) begin
            state_q <= ST_T2;
          end
        end
        ST_T2: begin
          // A pending register access also makes the unit leave the bus. [R14] [R20]
          if (fin) begin
            state_q <= (retry_q || (be && cs)) ? ST_TH : ST_IDLE;
          end
        end
        ST_TH: begin
          if (ph_q) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SLV: begin
          if (!cs || !slave_addr_strobe) begin
            state_q <= ST_IDLE; // [R22]
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_q <= 1'b0;
    end else begin
      ph_q <= (in_t1 | in_tw | in_t2 | in_th) ? ~ph_q : 1'b0;
    end
  end

  // Programmed wait states, loaded when the cycle starts. [R23]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wcnt_q <= WAIT_RST;
      nw_nz_q <= 1'b0;
      wfirst_q <= 1'b0;
    end else if (in_idle && start_ok && !slave_go) begin
      wcnt_q <= i_wait_count_bits;
      nw_nz_q <= |i_wait_count_bits;
      wfirst_q <= 1'b1;
    end else if (in_tw && ph_q) begin
      wcnt_q <= wcnt_q - 2'h1;
      wfirst_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Termination: a mid-state sample ends the next T2, 1.5 clocks later. [R4]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      term_q <= 1'b0;
    end else if (in_idle || into_t2) begin
      term_q <= 1'b0;
    end else if (mid_win && async_m && (be ? dsack_lo : rdy_lo)) begin
      term_q <= 1'b1; // [R2] [R12]
    end
  end

  // Sync termination at the start of T2 ends that same T2, one clock later. [R3] [R4]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      end_q <= 1'b0;
    end else if (in_idle) begin
      end_q <= 1'b0;
    end else if (into_t2) begin
      end_q <= term_q | (be & sync_cycle_end_lo) | (be & ~async_m & dsack_lo)
               | retry_q | retry_hit; // [R16]
    end
  end

  // A late async retry misses this cycle and is met again in the next one. [R17]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      retry_q <= 1'b0;
    end else if (in_idle) begin
      retry_q <= 1'b0;
    end else if (retry_hit && !in_th) begin
      retry_q <= 1'b1; // [R14]
    end
  end

  // A retried cycle reports no completion; the DMA request stays up and is rerun. [R15] [R16]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= fin & ~retry_q;
    end
  end

  // Setting wins over a clear in the same cycle. [R26]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_retry_status_bit <= 1'b0;
    end else if (fin && retry_q) begin
      o_retry_status_bit <= 1'b1;
    end else if (i_retry_status_clear) begin
      o_retry_status_bit <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Address, status and direction are held for the whole cycle. [R1]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_q <= ADDR_RST;
      stat_q <= STATUS_IDLE;
      wr_q <= 1'b0;
    end else if (in_idle && start_ok && !slave_go) begin
      addr_q <= i_xfer_addr;
      stat_q <= i_xfer_status;
      wr_q <= i_xfer_write;
    end else if (fin || in_slv) begin
      stat_q <= STATUS_IDLE;
    end
  end

  // One data register serves master writes and slave reads.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dout_q <= DATA_RST;
    end else if (in_idle && start_ok && !slave_go) begin
      dout_q <= i_xfer_wdata;
    end else if (in_slv && scnt_q == SLV_ACK_TICK - 3'h1) begin
      dout_q <= {16'h0000, rf_rdata}; // [R21] [R22]
    end
  end

  // Reads latch at mid-T2 of the last T2, or at its end in little-endian sync. [R6] [R11]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= DATA_RST;
    end else if (!wr_q && in_t2 && !ph_q && end_q && (be || async_m)) begin
      rdata_q <= din;
    end else if (!wr_q && fin && !be && !async_m) begin
      rdata_q <= din;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Strobe decode. The final T2 drops the strobes at its middle. [R7]
  assign t2_live = in_t2 & ~(ph_q & end_q);
  assign as_be = be & ((in_t1 & ph_q) | in_tw | t2_live); // [R1]
  // Big-endian reads strobe from mid-T1; little-endian async from start of T1. [R6] [R13]
  assign ds_rd = ~wr_q & (be ? as_be : (async_m & (in_t1 | in_tw | t2_live)));
  // Writes strobe only with waits: mid-first wait, or start of it in little-endian async. [R6] [R13]
  assign ds_wr = wr_q & nw_nz_q & (be ? ((in_tw & ~(wfirst_q & ~ph_q)) | t2_live)
                                      : (async_m & (in_tw | t2_live)));

  assign o_early_cycle_strobe_n = ~(in_t1 & ~ph_q); // [R1] [R9]
  assign o_addr_valid_strobe_be_n = ~as_be;
  assign o_addr_valid_strobe_le_n = ~(~be & in_t1); // [R9]
  assign o_data_valid_strobe_n = ~(ds_rd | ds_wr); // [R7]
  assign o_grant_acknowledge_n = ~(in_t1 | in_tw | in_t2); // [R14]
  assign o_addr = addr_q;
  assign o_bus_status_lines = stat_q;
  assign o_master_dir_be = ~wr_q;
  assign o_master_dir_le = wr_q;
  assign o_xfer_done = done_q;
  assign o_xfer_rdata = rdata_q;
  assign o_data = dout_q;
  // Write data is driven from mid-T1 until the cycle ends. [R6] [R11]
  assign o_data_oe_n = ~((wr_q & ((in_t1 & ph_q) | in_tw | in_t2)) | (ack & sdir));

  ////////////////////////////////////////////////////////////////////////////////
  // Slave cycle. Acknowledge is combinational so it drops as soon as either
  // strobe is seen inactive, at the price of a path from the synchroniser.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scnt_q <= 3'h0;
    end else if (!in_slv) begin
      scnt_q <= 3'h0;
    end else if (scnt_q != SLV_CNT_MAX) begin
      scnt_q <= scnt_q + 3'h1; // [R20]
    end
  end

  // Back-to-back accesses with chip select held need the strobe to toggle. [R19]
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      armed_q <= 1'b0;
    end else if (in_idle && slave_go) begin
      armed_q <= 1'b0;
    end else if (!slave_addr_strobe) begin
      armed_q <= 1'b1;
    end
  end

  assign ack = in_slv & (scnt_q >= SLV_ACK_TICK) & cs & slave_addr_strobe; // [R20] [R22]
  assign szack = in_slv & (scnt_q >= SLV_SZACK_TICK) & cs & slave_addr_strobe; // [R21]
  assign rf_we = in_slv & (scnt_q == SLV_WLATCH_TICK - 3'h1) & cs & slave_addr_strobe & ~sdir; // [R21]
  assign o_slave_mem_acknowledge_n = ~ack;
  // Both lines go low together: the unit answers as a 32-bit port. [R22]
  assign o_size_ack_out_n = {~szack, ~szack};

  sbcu_regfile u_regfile (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_wr_en(rf_we),
    .i_wr_idx(ridx),
    .i_wr_data(din[15:0]),
    .i_rd_idx(ridx),
    .o_rd_data(rf_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  property p_ecs_half;
    @(posedge i_ref_clk) disable iff (i_rst)
    $fell(o_early_cycle_strobe_n) |=> o_early_cycle_strobe_n;
  endproperty
  a_ecs_half: assert property (p_ecs_half) else $error("early strobe not one tick"); // [R1]

  property p_be_as;
    @(posedge i_ref_clk) disable iff (i_rst)
    ($fell(o_early_cycle_strobe_n) && be) |=> !o_addr_valid_strobe_be_n;
  endproperty
  a_be_as: assert property (p_be_as) else $error("address strobe late"); // [R1]

  property p_le_ads;
    @(posedge i_ref_clk) disable iff (i_rst)
    ($fell(o_early_cycle_strobe_n) && !be) |-> !o_addr_valid_strobe_le_n[*2] ##1
      o_addr_valid_strobe_le_n;
  endproperty
  a_le_ads: assert property (p_le_ads) else $error("le address strobe span"); // [R9]

  property p_retry_wins;
    @(posedge i_ref_clk) disable iff (i_rst)
    (fin && retry_q) |=> (!o_xfer_done && o_retry_status_bit && o_grant_acknowledge_n);
  endproperty
  a_retry_wins: assert property (p_retry_wins) else $error("retry not honoured"); // [R16]

  property p_zero_wait_wr;
    @(posedge i_ref_clk) disable iff (i_rst)
    ((in_t1 || in_t2) && wr_q && !nw_nz_q) |-> o_data_valid_strobe_n;
  endproperty
  a_zero_wait_wr: assert property (p_zero_wait_wr) else $error("strobe on zero-wait write"); // [R7]

  property p_waits3;
    @(posedge i_ref_clk) disable iff (i_rst)
    (in_t1 && ph_q && wcnt_q == 2'h3) |=> in_tw[*6] ##1 in_t2;
  endproperty
  a_waits3: assert property (p_waits3) else $error("wait count wrong"); // [R23]

  property p_slave_ack;
    @(posedge i_ref_clk) disable iff (i_rst)
    (in_idle && slave_go) |=> ##2 (!o_slave_mem_acknowledge_n || !cs || !slave_addr_strobe);
  endproperty
  a_slave_ack: assert property (p_slave_ack) else $error("slave ack late"); // [R20]

  property p_szack;
    @(posedge i_ref_clk) disable iff (i_rst)
    ($fell(o_slave_mem_acknowledge_n) ##0 (cs && slave_addr_strobe)[*5]) |-> o_size_ack_out_n == 2'h0;
  endproperty
  a_szack: assert property (p_szack) else $error("size ack not two clocks on"); // [R21]

  property p_release;
    @(posedge i_ref_clk) disable iff (i_rst)
    (!cs || !slave_addr_strobe) |-> (o_slave_mem_acknowledge_n && o_size_ack_out_n == 2'h3);
  endproperty
  a_release: assert property (p_release) else $error("slave lines not released"); // [R22]

  property p_sync_cycle_end_end;
    @(posedge i_ref_clk) disable iff (i_rst)
    (into_t2 && be && sync_cycle_end_lo) |=> ##1 fin;
  endproperty
  a_sync_cycle_end_end: assert property (p_sync_cycle_end_end) else $error("sync end not one clock"); // [R4]

endmodule

/* File: dv/sbcu_mem_model.sv */
// Memory and termination logic on the master side of the cycle unit.
// Assumes the bench picks bus mode, termination delay in ticks and the retry level.
`timescale 1ns/1ps
module sbcu_mem_model (
  // Clock, reset and bench control
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_endian,
  input wire logic i_sync,
  input wire logic i_retry_arm,
  input wire logic [2:0] i_lat,
  // Device master pins
  input wire logic [31:1] i_addr,
  input wire logic i_dir_be,
  input wire logic i_dir_le,
  input wire logic i_grant_n,
  input wire logic [31:0] i_data,
  input wire logic i_oe_n,
  // Answers to the device
  output logic [1:0] o_size_ack_n,
  output logic o_sync_end_n,
  output logic o_ready_n,
  output logic o_retry_n,
  output logic [31:0] o_data,
  output logic [31:0] o_wr_data
);
  logic [3:0] cnt_q;
  logic [31:0] last_q;
  logic term;
  logic rd;
  assign rd = ~i_grant_n & (i_endian ? i_dir_be : ~i_dir_le);
  // Held off two ticks or more, so termination is never seen during T1.
  assign term = ~i_grant_n & (cnt_q >= {1'b0, i_lat});
  assign o_size_ack_n = {2{~(term & i_endian & ~i_sync)}};
  assign o_sync_end_n = ~(term & i_endian & i_sync);
  assign o_ready_n = ~(term & ~i_endian);
  // The bench keeps the level past the hold state and pairs async sampling with async cycles.
  assign o_retry_n = ~i_retry_arm;
  // Released lines toggle, since a stale value could hide a late capture.
  assign o_data = rd ? ({i_addr, 1'b0} ^ 32'h5A5A_0F0F) : ~last_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
    end else if (i_grant_n) begin
      cnt_q <= 4'h0;
    end else if (cnt_q != 4'hF) begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      last_q <= 32'h0000_0000;
      o_wr_data <= 32'h0000_0000;
    end else begin
      last_q <= o_data;
      if (term & ~i_oe_n) begin
        o_wr_data <= i_data;
      end
    end
  end
endmodule

/* File: dv/sbcu_core_test.sv */
// Self-checking bench of the system bus cycle unit.
// Assumes the memory model answers master cycles; the bench plays the slave host.
`timescale 1ns/1ps
module sbcu_core_test;
  import sbcu_pkg::*;
  logic clk = 1'b0, rst = 1'b1, endian = 1'b1, sync = 1'b0, lrm = 1'b0, rss = 1'b0;
  logic rclr = 1'b0, req = 1'b0, wr = 1'b0, arm = 1'b0, cs_n = 1'b1, sas_n = 1'b1;
  logic sdir = 1'b1, hdrv = 1'b0, stat, done, gnt_n, dbe, dle, oe_n, ack_n;
  logic sy_n, rdy_n, rt_n;
  logic [1:0] waits = 2'h0, sz_n, szo_n;
  logic [2:0] st = 3'h7, lat = 3'h2, stl;
  logic [5:0] ridx = 6'h00;
  logic [31:1] addr = 31'h0, a_o;
  logic [31:0] wdata = 32'h0, hdata = 32'h0, rdata, mdata, ddata, dbus, wcap;
  logic [31:0] rnd = 32'hA4F1A5AD;
  int n_mismatch = 0, checks = 0;
  assign dbus = hdrv ? hdata : mdata;
  always #2.5 clk = ~clk;
  sbcu_core u_sbcu_core (.i_ref_clk(clk), .i_rst(rst), .i_bus_endian_select(endian),
    .i_sync_master_select(sync), .i_wait_count_bits(waits), .i_latched_retry_mode(lrm),
    .i_retry_sampling_select(rss), .i_retry_status_clear(rclr), .o_retry_status_bit(stat),
    .i_xfer_req(req), .i_xfer_write(wr), .i_xfer_addr(addr), .i_xfer_status(st),
    .i_xfer_wdata(wdata), .o_xfer_done(done), .o_xfer_rdata(rdata), .o_addr(a_o),
    .o_bus_status_lines(stl), .o_master_dir_be(dbe), .o_master_dir_le(dle),
    .o_early_cycle_strobe_n(), .o_addr_valid_strobe_be_n(), .o_addr_valid_strobe_le_n(),
    .o_data_valid_strobe_n(), .o_grant_acknowledge_n(gnt_n), .i_size_ack_pair_n(sz_n),
    .i_sync_cycle_end_n(sy_n), .i_ready_in_n(rdy_n), .i_retry_request_n(rt_n),
    .i_data(dbus), .o_data(ddata), .o_data_oe_n(oe_n), .i_chip_select_n(cs_n),
    .i_slave_addr_strobe_n(sas_n), .i_slave_dir(sdir), .i_register_index(ridx),
    .o_slave_mem_acknowledge_n(ack_n), .o_size_ack_out_n(szo_n));
  sbcu_mem_model u_sbcu_mem_model (.i_ref_clk(clk), .i_rst(rst), .i_endian(endian),
    .i_sync(sync), .i_retry_arm(arm), .i_lat(lat), .i_addr(a_o), .i_dir_be(dbe),
    .i_dir_le(dle), .i_grant_n(gnt_n), .i_data(ddata), .i_oe_n(oe_n), .o_size_ack_n(sz_n),
    .o_sync_end_n(sy_n), .o_ready_n(rdy_n), .o_retry_n(rt_n), .o_data(mdata),
    .o_wr_data(wcap));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] exp_rd(input logic [31:1] a);
    return {a, 1'b0} ^ 32'h5A5A_0F0F;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (n_mismatch == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Waits for the done pulse; a retry status seen first is reported in r.
  task automatic wait_done(output int n, output logic r);
    n = 0;
    r = 1'b0;
    do begin
      @(posedge clk);
      n++;
      if (stat === 1'b1 && done !== 1'b1) begin
        r = 1'b1;
      end
    end while (done !== 1'b1 && n < 400);
    req <= 1'b0;
  endtask
  task automatic start(input logic w);
    rnd = lfsr(rnd);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    addr <= rnd[31:1];
    wdata <= ~rnd;
    st <= rnd[2:0];
    lat <= 3'h2 + {1'b0, rnd[5:4]};
  endtask
  task automatic slv(input logic w, input logic [5:0] ix, input logic [15:0] d);
    int n;
    @(posedge clk);
    cs_n <= 1'b0;
    sas_n <= 1'b0;
    sdir <= ~w;
    ridx <= ix;
    hdrv <= w;
    hdata <= {~d, d};
    n = 0;
    do begin @(posedge clk); n++; end while (ack_n !== 1'b0 && n < 40);
    chk(32'(n <= 8), 32'h1);
    if (!w) begin
      chk(ddata, {16'h0000, d});
      chk({31'h0, oe_n}, 32'h0);
    end
    n = 0;
    do begin @(posedge clk); n++; end while (szo_n !== 2'h0 && n < 40);
    chk(n, 32'(SLV_SZACK_TICK - SLV_ACK_TICK));
    sas_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (3) @(posedge clk);
    hdrv <= 1'b0;
    chk({28'h0, ack_n, szo_n, oe_n}, 32'hF);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end
  initial begin
    int n;
    logic r;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      endian <= i[0];
      sync <= i[1];
      waits <= i[3:2];
      repeat (4) @(posedge clk);
      start(i[4] ^ rnd[7]);
      repeat (2) @(posedge clk);
      chk({29'h0, stl}, {29'h0, st});
      wait_done(n, r);
      chk(32'(n + 2 >= 4 + 2 * i[3:2]), 32'h1);
      chk({31'h0, r}, 32'h0);
      if (wr === 1'b1) begin
        chk(wcap, wdata);
      end else begin
        chk(rdata, exp_rd(addr));
      end
    end
    // Retry with normal termination also pending: plain then latched mode.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk);
      endian <= 1'b1;
      lrm <= k[0];
      rss <= k[0];
      sync <= ~k[0];
      repeat (4) @(posedge clk);
      start(1'b0);
      // Retry rises with the request, since latched mode holds off a start while it is seen.
      arm <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (stat !== 1'b1 && done !== 1'b1 && n < 400);
      chk({31'h0, stat}, 32'h1);
      repeat (8) @(posedge clk);
      arm <= 1'b0;
      if (k == 1) begin
        repeat (20) @(posedge clk);
        chk({30'h0, done, req}, 32'h1);
        rclr <= 1'b1;
        @(posedge clk);
        rclr <= 1'b0;
      end
      wait_done(n, r);
      chk({31'h0, done}, 32'h1);
      chk(rdata, exp_rd(addr));
      rclr <= 1'b1;
      @(posedge clk);
      rclr <= 1'b0;
      @(posedge clk);
      chk({31'h0, stat}, 32'h0);
    end
    @(posedge clk);
    endian <= 1'b1;
    repeat (4) @(posedge clk);
    rnd = lfsr(rnd);
    slv(1'b1, 6'h00, rnd[15:0]);
    slv(1'b1, 6'h3F, rnd[31:16]);
    slv(1'b0, 6'h00, rnd[15:0]);
    slv(1'b0, 6'h3F, rnd[31:16]);
    conclude();
  end
endmodule
